// file: hdl/stsc_params.svh
`ifndef STSC_PARAMS_SVH
`define STSC_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define STSC_CONF_IDX       8'h02
`define STSC_CONF_ADDR      (8'(`STSC_CONF_IDX * 4))
`define STSC_STATUS_ADDR    8'h0C
`define STSC_PARAM_BASE     8'h10
`define STSC_SHADOW_BASE    8'h40
`define STSC_CONF_RESET     32'h0000_0000
`define STSC_CONF_MASK      32'h0003_FFFF

// ----------------------------------------------------------------
// Field positions of start_trigger_config
// ----------------------------------------------------------------
`define STSC_HOLD_LSB       0
`define STSC_SHADOW_EN_BIT  4
`define STSC_TRIG_LSB       5
`define STSC_POL_BIT        9
`define STSC_IMM_BIT        10
`define STSC_BUSY_BIT       11
`define STSC_PIPE_LSB       12
`define STSC_DEPTH_LSB      16

// ----------------------------------------------------------------
// Ramp parameter layout
// ----------------------------------------------------------------
`define STSC_NUM_RAMP       13
`define STSC_BEGIN_VEL_IDX  4'h0
`define STSC_END_VEL_IDX    4'h1

`endif

// file: hdl/stsc_pkg.sv
`default_nettype none

package stsc_pkg;
  // Parameters held behind start signals
  typedef enum logic [2:0] {
    PRM_GOAL, PRM_PEAK, PRM_PROFILE, PRM_GEAR, PRM_COMPARE, PRM_GLOBAL
  } stsc_prm_t;

  // Shadow staging depth option
  typedef enum logic [1:0] {
    DEPTH_SINGLE, DEPTH_S_RAMP, DEPTH_TRAP_NO_END, DEPTH_TRAP_NO_BEGIN
  } stsc_depth_t;

  // Start pin drive state
  typedef enum {PIN_IDLE, PIN_PULSE} stsc_pin_state_t;
endpackage : stsc_pkg

`default_nettype wire

// file: hdl/stsc_pin_if.sv
`default_nettype none

interface stsc_pin_if;
  logic pol_high;   // Active level of the start pin
  logic as_input;   // Pin receives starts
  logic busy_en;    // Busy handshake drive
  logic gen_en;     // Any trigger source selected
  logic start;      // Start signal of this cycle
  logic ext_start;  // External start seen on the pin

  modport ctrl (output pol_high, as_input, busy_en, gen_en, start, input ext_start);
  modport pin  (input pol_high, as_input, busy_en, gen_en, start, output ext_start);
endinterface : stsc_pin_if

`default_nettype wire

// file: hdl/stsc_start_pin.sv
`default_nettype none

module stsc_start_pin
  import stsc_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  // Control side
  stsc_pin_if.pin    cp,
  // Pin side
  input  wire logic  pin_in,
  output var  logic  pin_out,
  output var  logic  pin_oe,
  output var  logic  pin_weak
);

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  logic            active_now;
  logic            active_prev_reg;
  stsc_pin_state_t state_reg;
  stsc_pin_state_t state_next;

  // Active level after polarity, rising of it is a start
  assign active_now    = (pin_in == cp.pol_high);
  assign cp.ext_start  = cp.as_input & active_now & ~active_prev_reg;

  // Output pulse sequencing
  always_comb begin
    case (state_reg)
      PIN_IDLE:  state_next = (cp.start & ~cp.as_input & cp.gen_en) ? PIN_PULSE : PIN_IDLE;
      PIN_PULSE: state_next = PIN_IDLE;
      default:   state_next = PIN_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      active_prev_reg <= 1'b0;
      state_reg       <= PIN_IDLE;
      pin_out         <= 1'b0;
      pin_oe          <= 1'b0;
      pin_weak        <= 1'b0;
    end else if (ce) begin
      active_prev_reg <= active_now;
      state_reg       <= state_next;
      if (cp.as_input) begin
        pin_out  <= cp.pol_high;
        pin_oe   <= cp.busy_en;
        pin_weak <= cp.busy_en;
      end else begin
        pin_out  <= (state_next == PIN_PULSE) ? cp.pol_high : ~cp.pol_high;
        pin_oe   <= cp.gen_en;
        pin_weak <= 1'b0;
      end
    end
  end

endmodule : stsc_start_pin

`default_nettype wire

// file: hdl/stsc_top.sv
// ----------------------------------------------------------------
// Notes on behaviour
// - Goal and peak velocity wait for start
// - Profile and gearing changes wait for start
// - Hold bit 4 enables ramp shadow registers
// - Empty trigger mask: no starts at all
// - Trigger bit 0 selects pin input
// - Reached events selectable as start triggers
// - Polarity bit sets pin active level
// - Immediate bit bypasses the start timer
// - Busy bit: weak drive at active level on input pin
// - Pipeline mask holds four values until start
// - Depth 0: single shadow, 13 parameters
// - Depths 1-3: double stage, trapezoid exclusions
// ----------------------------------------------------------------
`include "stsc_params.svh"
`default_nettype none

module stsc_top
  import stsc_pkg::*;
#(
  parameter int NUM_RAMP = `STSC_NUM_RAMP
) (
  // Clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  // Motion events
  input  wire logic                     target_reached_evt,
  input  wire logic                     velocity_reached_evt,
  input  wire logic                     compare_hit_event,
  // Start timer
  input  wire logic                     timer_done,
  output var  logic                     timer_launch,
  // Start pin
  input  wire logic                     start_pin_in,
  output var  logic                     start_pin_out,
  output var  logic                     start_pin_oe,
  output var  logic                     start_pin_weak,
  // Active values
  output var  logic                     start_strobe,
  output var  logic [31:0]              goal_position,
  output var  logic [31:0]              peak_velocity,
  output var  logic [31:0]              profile_select,
  output var  logic [31:0]              gearing_factor,
  output var  logic [31:0]              compare_position,
  output var  logic [31:0]              global_settings,
  output var  logic [NUM_RAMP*32-1:0]   ramp_active
);

  localparam int NUM_PRM = 6;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction : hit

  logic [31:0] conf_reg;
  logic [31:0] act_reg  [NUM_PRM];
  logic [31:0] pend_reg [NUM_PRM];
  logic [NUM_PRM-1:0] pend_flag_reg;
  logic [31:0] sh_act_reg [NUM_RAMP];
  logic [31:0] sh1_reg    [NUM_RAMP];
  logic [31:0] sh2_reg    [NUM_RAMP];
  logic [7:0]  start_cnt_reg;

  logic        setup;
  logic        wr_en;
  logic        conf_hit;
  logic        status_hit;
  logic [NUM_PRM-1:0]  prm_hit;
  logic        sh_area;
  logic [3:0]  sh_idx;
  logic        sh_hit;
  logic        mapped;
  logic [31:0] rd_value;

  assign setup      = psel & ~penable;
  assign wr_en      = ce & psel & penable & pready & pwrite & ~pslverr;
  assign conf_hit   = hit(paddr, `STSC_CONF_ADDR);
  assign status_hit = hit(paddr, `STSC_STATUS_ADDR);
  assign sh_area    = (paddr[7:6] == 2'h1) & (paddr[1:0] == 2'h0);
  assign sh_idx     = paddr[5:2];
  assign sh_hit     = sh_area & (32'(sh_idx) < NUM_RAMP);

  // Parameter register decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PRM; gi++) begin : g_dec
      assign prm_hit[gi] = hit(paddr, 8'(`STSC_PARAM_BASE + 4 * gi));
    end
  endgenerate

  assign mapped = conf_hit | status_hit | (|prm_hit) | sh_hit;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  logic [4:0]  hold_mask;
  logic        shadow_en;
  logic [3:0]  trig_mask;
  logic        pol_high;
  logic        immediate;
  logic        busy_en;
  logic [3:0]  pipe_mask;
  stsc_depth_t depth;
  logic        gen_en;

  assign hold_mask = conf_reg[`STSC_HOLD_LSB +: 5];
  assign shadow_en = conf_reg[`STSC_SHADOW_EN_BIT];
  assign trig_mask = conf_reg[`STSC_TRIG_LSB +: 4];
  assign pol_high  = conf_reg[`STSC_POL_BIT];
  assign immediate = conf_reg[`STSC_IMM_BIT];
  assign busy_en   = conf_reg[`STSC_BUSY_BIT];
  assign pipe_mask = conf_reg[`STSC_PIPE_LSB +: 4];
  assign depth     = stsc_depth_t'(conf_reg[`STSC_DEPTH_LSB +: 2]);
  assign gen_en    = |trig_mask;

  // Which parameters wait for a start signal
  logic [NUM_PRM-1:0] held;
  assign held[PRM_GOAL]    = hold_mask[0] | pipe_mask[0];
  assign held[PRM_PEAK]    = hold_mask[1];
  assign held[PRM_PROFILE] = hold_mask[2];
  assign held[PRM_GEAR]    = hold_mask[3] | pipe_mask[2];
  assign held[PRM_COMPARE] = pipe_mask[1];
  assign held[PRM_GLOBAL]  = pipe_mask[3];

  // ----------------------------------------------------------------
  // Start signal generation
  // ----------------------------------------------------------------
  stsc_pin_if pif ();
  logic ext_go;
  logic start;

  assign pif.pol_high = pol_high;
  assign pif.as_input = trig_mask[0];
  assign pif.busy_en  = busy_en;
  assign pif.gen_en   = gen_en;
  assign pif.start    = start;

  // External start acts directly or after the timer
  assign ext_go = immediate ? pif.ext_start : timer_done;
  assign start  = gen_en & ((trig_mask[0] & ext_go)
                          | (trig_mask[1] & target_reached_evt)
                          | (trig_mask[2] & velocity_reached_evt)
                          | (trig_mask[3] & compare_hit_event));

  stsc_start_pin u_pin (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .cp       (pif.pin),
    .pin_in   (start_pin_in),
    .pin_out  (start_pin_out),
    .pin_oe   (start_pin_oe),
    .pin_weak (start_pin_weak)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] status_value;
  logic [31:0] prm_rd;
  logic [31:0] sh_rd;

  assign status_value = {16'h0000, start_cnt_reg, 1'b0, pend_flag_reg, trig_mask[0]};
  assign sh_rd        = sh_hit ? sh_act_reg[sh_idx] : 32'h0000_0000;

  always_comb begin
    prm_rd = 32'h0000_0000;
    for (int i = 0; i < NUM_PRM; i++) begin
      if (prm_hit[i]) begin
        prm_rd = act_reg[i];
      end
    end
  end

  assign rd_value = conf_hit   ? (conf_reg & `STSC_CONF_MASK) :
                    status_hit ? status_value :
                    (|prm_hit) ? prm_rd : sh_rd;

  // APB answer is registered in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite & mapped) ? rd_value : 32'h0000_0000;
    end
  end

  // Configuration register and start bookkeeping
  always_ff @(posedge clk) begin
    if (rst) begin
      conf_reg      <= `STSC_CONF_RESET;
      start_cnt_reg <= 8'h00;
      start_strobe  <= 1'b0;
      timer_launch  <= 1'b0;
    end else if (ce) begin
      if (wr_en & conf_hit) begin
        conf_reg <= pwdata & `STSC_CONF_MASK;
      end
      start_cnt_reg <= start_cnt_reg + 8'(start);
      start_strobe  <= start;
      timer_launch  <= gen_en & trig_mask[0] & ~immediate & pif.ext_start;
    end
  end

  // ----------------------------------------------------------------
  // Held parameters
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < NUM_PRM; gi++) begin : g_prm
      logic wr_hit;
      assign wr_hit = wr_en & prm_hit[gi];
      // Start copies pending value; a later write in that cycle pends again
      always_ff @(posedge clk) begin
        if (rst) begin
          act_reg[gi]       <= 32'h0000_0000;
          pend_reg[gi]      <= 32'h0000_0000;
          pend_flag_reg[gi] <= 1'b0;
        end else if (ce) begin
          if (start & pend_flag_reg[gi]) begin
            act_reg[gi]       <= pend_reg[gi];
            pend_flag_reg[gi] <= 1'b0;
          end
          if (wr_hit & held[gi]) begin
            pend_reg[gi]      <= pwdata;
            pend_flag_reg[gi] <= 1'b1;
          end else if (wr_hit) begin
            act_reg[gi]       <= pwdata;
          end
        end
      end
    end
  endgenerate

  assign goal_position    = act_reg[PRM_GOAL];
  assign peak_velocity    = act_reg[PRM_PEAK];
  assign profile_select   = act_reg[PRM_PROFILE];
  assign gearing_factor   = act_reg[PRM_GEAR];
  assign compare_position = act_reg[PRM_COMPARE];
  assign global_settings  = act_reg[PRM_GLOBAL];

  // ----------------------------------------------------------------
  // Ramp shadow registers
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < NUM_RAMP; gi++) begin : g_sh
      logic dbl;
      logic wr_hit;
      // Double stage for depths 1-3 unless this parameter is excluded by the option
      assign dbl = (depth == DEPTH_S_RAMP)
                 | ((depth == DEPTH_TRAP_NO_END) & (4'(gi) != `STSC_END_VEL_IDX))
                 | ((depth == DEPTH_TRAP_NO_BEGIN) & (4'(gi) != `STSC_BEGIN_VEL_IDX));
      assign wr_hit = wr_en & sh_hit & (sh_idx == 4'(gi));
      always_ff @(posedge clk) begin
        if (rst) begin
          sh_act_reg[gi] <= 32'h0000_0000;
          sh1_reg[gi]    <= 32'h0000_0000;
          sh2_reg[gi]    <= 32'h0000_0000;
        end else if (ce) begin
          if (start & shadow_en) begin
            sh_act_reg[gi] <= sh1_reg[gi];
            if (dbl) begin
              sh1_reg[gi] <= sh2_reg[gi];
            end
          end
          if (wr_hit & ~shadow_en) begin
            sh_act_reg[gi] <= pwdata;
          end else if (wr_hit & dbl) begin
            sh2_reg[gi] <= pwdata;
          end else if (wr_hit) begin
            sh1_reg[gi] <= pwdata;
          end
        end
      end
      assign ramp_active[gi*32 +: 32] = sh_act_reg[gi];
    end
  endgenerate

endmodule : stsc_top

`default_nettype wire

// file: tb/stsc_start_src.sv
`default_nettype none

// ----------------------------------------------------------------
// Far-side start source sharing the start pin
// ----------------------------------------------------------------
module stsc_start_src (
  // Requests from the bench
  input  wire logic fire,
  input  wire logic pol_high,
  // Design pin drive
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pin_weak,
  // Resolved pin level
  output var  logic level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strong design drive wins, then this source, which idles at inactive
  always_comb begin
    if (pin_oe && !pin_weak) begin
      level = pin_out;
    end else if (fire) begin
      level = pol_high;
    end else begin
      level = !pol_high;
    end
  end
endmodule : stsc_start_src

`default_nettype wire

// file: tb/stsc_chk.sv
`default_nettype none

module stsc_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events and timer
  input wire logic        target_reached_evt,
  input wire logic        velocity_reached_evt,
  input wire logic        compare_hit_event,
  input wire logic        timer_done,
  input wire logic        timer_launch,
  // Pin and results
  input wire logic        start_pin_out,
  input wire logic        start_pin_oe,
  input wire logic        start_pin_weak,
  input wire logic        start_strobe,
  input wire logic [31:0] goal_position
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Copy of the configuration and its age
  // ----------------------------------------------------------------
  logic [17:0] conf_reg;
  logic [1:0]  age_reg;
  wire         setup    = psel && !penable;
  wire         wr_done  = psel && penable && pready && pwrite;
  wire         wr_goal  = wr_done && paddr == 8'h10;
  wire         settled  = age_reg[1];
  wire [3:0]   trig     = conf_reg[8:5];
  wire         mapped   = paddr[1:0] == 2'h0 && paddr inside {[8'h08:8'h24], [8'h40:8'h70]};
  wire         ev_start = |(trig[3:1] & {compare_hit_event, velocity_reached_evt,
                                         target_reached_evt});
  wire         quiet    = !target_reached_evt && !velocity_reached_evt &&
                          !compare_hit_event && !timer_done;

  // Track writes; pin outputs lag the register by one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      conf_reg <= '0;
      age_reg  <= 2'h3;
    end else if (wr_done && paddr == 8'h08) begin
      conf_reg <= pwdata[17:0];
      age_reg  <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg  <= age_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_apb_one_wait: assert property (setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_goal_held: assert property (wr_goal && conf_reg[0] && quiet |=> $stable(goal_position))
    else $error("held goal changed without start");
  a_goal_direct: assert property (
    wr_goal && !conf_reg[0] && !conf_reg[12] |=> goal_position == $past(pwdata))
    else $error("unheld goal not applied");
  a_no_trigger: assert property (trig == 4'h0 && $past(trig) == 4'h0 |-> !start_strobe)
    else $error("start with empty trigger mask");
  a_event_start: assert property (ev_start |=> start_strobe)
    else $error("selected event gave no start");
  a_timer_start: assert property (trig[0] && !conf_reg[10] && timer_done |=> start_strobe)
    else $error("timer done gave no start");
  a_no_launch: assert property (settled && (conf_reg[10] || !trig[0]) |-> !timer_launch)
    else $error("timer launched outside timer path");
  a_idle_pin: assert property (settled && trig == 4'h0 |-> !start_pin_oe)
    else $error("pin driven with no triggers");
  a_out_level: assert property (settled && !trig[0] && trig != 4'h0 |->
    start_pin_oe && !start_pin_weak &&
    start_pin_out == (start_strobe ? conf_reg[9] : !conf_reg[9]))
    else $error("output pin level wrong");
  a_in_plain: assert property (settled && trig[0] && !conf_reg[11] |-> !start_pin_oe)
    else $error("input pin driven");
  a_in_busy: assert property (settled && trig[0] && conf_reg[11] |->
    start_pin_oe && start_pin_weak && start_pin_out == conf_reg[9])
    else $error("busy input drive wrong");
endmodule : stsc_chk

`default_nettype wire

// file: tb/start_trigger_shadow_config_tb.sv
`default_nettype none

module start_trigger_shadow_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk, rst, psel, penable, pwrite, fire, timer_done, pol;
  logic             prdy, perr, tl, pout, poe, pweak, strobe, level, errq;
  logic [2:0]       evt;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdq, goal, peak, prof, gear, comp, glob;
  logic [13*32-1:0] ramp;
  logic [5:0][31:0] act;
  logic [31:0]      cf  [8] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h1000, 32'h2000,
                                32'h4000, 32'h8000};
  int               pi  [8] = '{0, 1, 2, 3, 0, 4, 3, 5};
  int               miscompares, tests_run, launches;

  assign act = {glob, comp, gear, prof, peak, goal};

  stsc_top stsc_top_i (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(prdy),
    .pslverr(perr), .target_reached_evt(evt[0]), .velocity_reached_evt(evt[1]),
    .compare_hit_event(evt[2]), .timer_done(timer_done), .timer_launch(tl),
    .start_pin_in(level), .start_pin_out(pout), .start_pin_oe(poe),
    .start_pin_weak(pweak), .start_strobe(strobe), .goal_position(goal),
    .peak_velocity(peak), .profile_select(prof), .gearing_factor(gear),
    .compare_position(comp), .global_settings(glob), .ramp_active(ramp));

  stsc_start_src stsc_start_src_i (.fire(fire), .pol_high(pol),
    .pin_out(pout), .pin_oe(poe), .pin_weak(pweak), .level(level));

  // Clock and launch counter
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tl === 1'b1) begin
      launches++;
    end
  end

  task automatic give_verdict;
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One APB transfer; returns after one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdq  = prdata;
    errq = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask : rd

  task automatic pulse(input int i);
    evt <= 3'(1 << i);
    @(posedge clk);
    evt <= 3'h0;
  endtask : pulse

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, old;
    logic [7:0]  a;
    {rst, psel, penable, pwrite, fire, timer_done, evt, paddr, pwdata, pol} = '0;
    rst = 1'b1;
    tick(10);
    rst <= 1'b0;
    rd(8'h08, 32'h0);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0003_FFFF);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, errq}, 32'h1);
    wr(8'h08, 32'h1);
    wr(8'h10, 32'h1111_0000);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      tick(2);
    end
    chk(goal, 32'h0);
    for (int k = 0; k < 8; k++) begin
      a   = 8'(8'h10 + 4 * pi[k]);
      v   = 32'hA000_0000 + 32'(k);
      old = act[pi[k]];
      wr(8'h08, cf[k] | (32'h20 << (1 + k % 3)));
      wr(a, v);
      tick(2);
      chk(act[pi[k]], old);
      pulse(k % 3);
      tick(3);
      chk(act[pi[k]], v);
      rd(a, v);
    end
    wr(8'h08, 32'h40);
    wr(8'h54, 32'h0B0B_0001);
    wr(8'h10, 32'h0B0B_0002);
    tick(2);
    chk(ramp[5*32 +: 32], 32'h0B0B_0001);
    chk(goal, 32'h0B0B_0002);
    for (int d = 0; d < 4; d++) begin
      v   = 32'hB000_0000 + 32'(d);
      old = ramp[5*32 +: 32];
      wr(8'h08, 32'h50 | (32'(d) << 16));
      wr(8'h54, v);
      tick(2);
      chk(ramp[5*32 +: 32], old);
      pulse(0);
      tick(3);
      if (d != 0) begin
        pulse(0);
        tick(3);
      end
      chk(ramp[5*32 +: 32], v);
    end
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      wr(8'h08, 32'h421 | (32'(p) << 9));
      tick(3);
      wr(8'h10, 32'hC000_0000 + 32'(p));
      fire <= 1'b1;
      tick(2);
      fire <= 1'b0;
      tick(6);
      chk(goal, 32'hC000_0000 + 32'(p));
    end
    wr(8'h08, 32'h221);
    tick(3);
    launches = 0;
    wr(8'h10, 32'hD000_0000);
    fire <= 1'b1;
    tick(2);
    fire <= 1'b0;
    tick(8);
    chk(32'(launches), 32'h1);
    chk(goal, 32'hC000_0001);
    timer_done <= 1'b1;
    tick(1);
    timer_done <= 1'b0;
    tick(3);
    chk(goal, 32'hD000_0000);
    wr(8'h08, 32'hA20);
    tick(3);
    chk({29'h0, poe, pweak, pout}, 32'h7);
    pol <= 1'b0;
    wr(8'h08, 32'h840);
    tick(3);
    chk({29'h0, poe, pweak, pout}, 32'h5);
    // Excluded velocity stays single stage under the trapezoid options
    for (int d = 2; d < 4; d++) begin
      wr(8'h08, 32'h50 | (32'(d) << 16));
      wr(8'(8'h4C - 4 * d), 32'hE000_0000 + 32'(d));
      pulse(0);
      tick(3);
      chk(ramp[(3 - d)*32 +: 32], 32'hE000_0000 + 32'(d));
    end
    // Mid-run reset, then a held goal released by the timer path
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    chk(goal | ramp[5*32 +: 32] | {31'h0, poe}, 32'h0);
    wr(8'h08, 32'h21);
    wr(8'h10, 32'hF000_0000);
    rd(8'h0C, 32'h0000_0003);
    timer_done <= 1'b1;
    tick(1);
    timer_done <= 1'b0;
    tick(2);
    rd(8'h0C, 32'h0000_0101);
    chk(goal, 32'hF000_0000);
    give_verdict();
  end
endmodule : start_trigger_shadow_config_tb

bind stsc_top stsc_chk stsc_chk_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .target_reached_evt(target_reached_evt),
  .velocity_reached_evt(velocity_reached_evt), .compare_hit_event(compare_hit_event),
  .timer_done(timer_done), .timer_launch(timer_launch), .start_pin_out(start_pin_out),
  .start_pin_oe(start_pin_oe), .start_pin_weak(start_pin_weak),
  .start_strobe(start_strobe), .goal_position(goal_position));

`default_nettype wire
